/* File: src/fieldbus_io_image.v */
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "fieldbus_io_consts.vh"

module fieldbus_io_image (
  input wire REF_CLK,
  input wire RESETN,
  input wire [3:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire [3:0] DIGITAL_INPUTS,
  output reg [3:0] DIGITAL_OUTPUTS,
  input wire [3:0] OUTPUT_OVERLOAD,
  input wire SENSOR_SUPPLY_LOW,
  input wire SENSOR_SUPPLY_OVERLOAD,
  input wire LOGIC_SUPPLY_LOW,
  input wire [3:0] ADDRESS_TENS_SWITCH,
  input wire [3:0] ADDRESS_UNITS_SWITCH,
  output reg [6:0] STATION_ADDRESS,
  output reg STATION_VALID,
  output reg [7:0] TELEGRAM_BYTE,
  output reg TELEGRAM_VALID,
  output reg IRQ
);
  // ==========================================
  // State
  reg [7:0] input_image_reg;
  reg [7:0] output_image_reg;
  reg [7:0] station_status1_reg;
  reg [7:0] station_status2_reg;
  reg [7:0] station_status3_reg;
  reg [7:0] diag_master_reg;
  reg [7:0] diag_byte_reg;
  reg [7:0] prev_diag_reg;
  reg [1:0] irq_status_reg;
  reg [1:0] irq_mask_reg;
  reg [3:0] frame_index_reg;
  reg strapped_reg;
  reg send_pending_reg;
  wire [7:0] diag_byte_next;
  wire [103:0] frame;
  wire [6:0] switch_value;
  wire diag_event;
  wire sender_busy;
  wire sender_done;
  wire [7:0] sender_byte;
  wire sender_valid;
  reg [1:0] irq_status_next;
  // High half goes out first, so it sits in the lower frame byte
  localparam [15:0] ident_code = `IDENT_CODE;

  // Sensible decimal conversion of the two rotary switches
  function [6:0] bcd_to_bin;
    input [3:0] tens;
    input [3:0] units;
    reg [6:0] t;
    begin
      t = {3'h0, tens};
      bcd_to_bin = (t << 3) + (t << 1) + {3'h0, units};
    end
  endfunction

  // Frame byte selector for the software read; the sender indexes the frame itself
  function [7:0] frame_byte;
    input [103:0] f;
    input [3:0] idx;
    begin
      if (idx <= `FRAME_LAST)
        frame_byte = f[idx*8 +: 8];
      else
        frame_byte = 8'h00;
    end
  endfunction

  // ==========================================
  // Live diagnostic byte, never latched
  assign diag_byte_next = {SENSOR_SUPPLY_OVERLOAD,
                           LOGIC_SUPPLY_LOW,
                           |OUTPUT_OVERLOAD,
                           1'b0,
                           SENSOR_SUPPLY_LOW,
                           3'h0};

  // Frame assembled byte 0 in the low bits
  assign frame = {8'h00,
                  32'h0000_0000,
                  diag_byte_reg,
                  `DIAG_HEADER,
                  ident_code[7:0],
                  ident_code[15:8],
                  diag_master_reg,
                  station_status3_reg,
                  station_status2_reg,
                  station_status1_reg};

  assign switch_value = bcd_to_bin(ADDRESS_TENS_SWITCH, ADDRESS_UNITS_SWITCH);
  assign diag_event = (diag_byte_reg != prev_diag_reg);

  diag_frame_sender u_sender (
    .clk(REF_CLK),
    .resetn(RESETN),
    .start(send_pending_reg),
    .frame(frame),
    .byte_out(sender_byte),
    .byte_valid(sender_valid),
    .busy(sender_busy),
    .done(sender_done)
  );

  // ==========================================
  // Sticky interrupt bits; a new event beats the clear in the same cycle
  always @* begin
    irq_status_next = irq_status_reg;
    if (WR && ADDR == `REG_IRQ_STATUS)
      irq_status_next = irq_status_reg & ~WDATA[1:0];
    if (diag_event)
      irq_status_next[`IRQ_DIAG_CHANGE] = 1'b1;
    if (sender_done)
      irq_status_next[`IRQ_FRAME_DONE] = 1'b1;
  end

  // ==========================================
  // One strobe at one offset; used by every write decode except the interrupt status clear
  function port_hit;
    input strobe;
    input [3:0] addr;
    input [3:0] offset;
    begin
      port_hit = strobe && (addr == offset);
    end
  endfunction

  wire wr_output = port_hit(WR, ADDR, `REG_OUTPUT_IMAGE);
  wire wr_mask = port_hit(WR, ADDR, `REG_IRQ_MASK);
  wire wr_index = port_hit(WR, ADDR, `REG_FRAME_INDEX);
  wire wr_status1 = port_hit(WR, ADDR, `REG_STATION);
  wire wr_status2 = port_hit(WR, ADDR, `REG_STATION2);
  wire wr_status3 = port_hit(WR, ADDR, `REG_STATION3);
  wire wr_master = port_hit(WR, ADDR, `REG_DIAG_MASTER);
  // Digits above nine can still give a 7-bit sum in the legal range, directly or by wrapping
  wire digits_ok = (ADDRESS_TENS_SWITCH <= `BCD_DIGIT_MAX) && (ADDRESS_UNITS_SWITCH <= `BCD_DIGIT_MAX);
  reg [7:0] rdata_next;

  // ==========================================
  // Process image
  // Inputs pass one register so a read never sees a pin mid-change
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      input_image_reg <= 8'h00;
      DIGITAL_OUTPUTS <= 4'h0;
    end else begin
      input_image_reg <= {4'h0, DIGITAL_INPUTS};
      // Upper nibble is dropped here, so nothing written there reaches a pin
      DIGITAL_OUTPUTS <= output_image_reg[3:0];
    end
  end

  // ==========================================
  // Software-written registers
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      output_image_reg <= 8'h00;
      irq_mask_reg <= 2'h0;
      frame_index_reg <= 4'h0;
      station_status1_reg <= 8'h00;
      station_status2_reg <= 8'h00;
      station_status3_reg <= 8'h00;
      diag_master_reg <= `DIAG_MASTER_RESET;
    end else begin
      // The whole byte is kept so software reads back what it wrote
      if (wr_output) begin
        output_image_reg <= WDATA;
      end
      if (wr_mask) begin
        irq_mask_reg <= WDATA[1:0];
      end
      if (wr_index) begin
        frame_index_reg <= WDATA[3:0];
      end
      // Station status bytes are kept up to date by the link software
      if (wr_status1) begin
        station_status1_reg <= WDATA;
      end
      if (wr_status2) begin
        station_status2_reg <= WDATA;
      end
      if (wr_status3) begin
        station_status3_reg <= WDATA;
      end
      if (wr_master) begin
        diag_master_reg <= WDATA;
      end
    end
  end

  // ==========================================
  // Diagnostic byte and change detection
  // Both start at zero, so flags already set at release count as an event
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      diag_byte_reg <= 8'h00;
      prev_diag_reg <= 8'h00;
    end else begin
      diag_byte_reg <= diag_byte_next;
      prev_diag_reg <= diag_byte_reg;
    end
  end

  // ==========================================
  // Station address, caught once after reset release
  // Later switch turns are ignored until the next reset
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      strapped_reg <= 1'b0;
      STATION_ADDRESS <= 7'h00;
      STATION_VALID <= 1'b0;
    end else if (!strapped_reg) begin
      strapped_reg <= 1'b1;
      STATION_ADDRESS <= switch_value;
      STATION_VALID <= digits_ok && (switch_value >= `STATION_MIN) && (switch_value <= `STATION_MAX);
    end
  end

  // ==========================================
  // Telegram request and byte output
  // A change arriving mid-send queues exactly one more telegram, never more
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      send_pending_reg <= 1'b0;
      TELEGRAM_BYTE <= 8'h00;
      TELEGRAM_VALID <= 1'b0;
    end else begin
      if (diag_event) begin
        send_pending_reg <= 1'b1;
      end else if (!sender_busy) begin
        send_pending_reg <= 1'b0;
      end
      // Retimed so the telegram pins come straight from flip-flops
      TELEGRAM_BYTE <= sender_byte;
      TELEGRAM_VALID <= sender_valid;
    end
  end

  // ==========================================
  // Interrupt status and level output
  // A mask write takes effect one cycle after it lands
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_status_reg <= 2'h0;
      IRQ <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      IRQ <= |(irq_status_next & irq_mask_reg);
    end
  end

  // ==========================================
  // Read decode; every read sees live data
  always @* begin
    rdata_next = 8'h00;
    if (RD) begin
      case (ADDR)
        `REG_INPUT_IMAGE: rdata_next = input_image_reg;
        `REG_OUTPUT_IMAGE: rdata_next = output_image_reg;
        `REG_STATION: rdata_next = station_status1_reg;
        `REG_DIAG_STATUS: rdata_next = diag_byte_reg;
        `REG_IRQ_STATUS: rdata_next = {6'h00, irq_status_reg};
        `REG_IRQ_MASK: rdata_next = {6'h00, irq_mask_reg};
        `REG_FRAME_INDEX: rdata_next = {4'h0, frame_index_reg};
        `REG_FRAME_DATA: rdata_next = frame_byte(frame, frame_index_reg);
        `REG_STATION_ADDR: rdata_next = {STATION_VALID, STATION_ADDRESS};
        `REG_STATION2: rdata_next = station_status2_reg;
        `REG_STATION3: rdata_next = station_status3_reg;
        `REG_DIAG_MASTER: rdata_next = diag_master_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Read data stand one cycle after the strobe and are zero otherwise
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= rdata_next;
    end
  end
endmodule

/* File: include/fieldbus_io_consts.vh */
`ifndef FIELDBUS_IO_CONSTS_VH
`define FIELDBUS_IO_CONSTS_VH
// Register offsets on the plain software port
`define REG_INPUT_IMAGE   4'h0
`define REG_OUTPUT_IMAGE  4'h1
`define REG_STATION       4'h2
`define REG_DIAG_STATUS   4'h3
`define REG_IRQ_STATUS    4'h4
`define REG_IRQ_MASK      4'h5
`define REG_FRAME_INDEX   4'h6
`define REG_FRAME_DATA    4'h7
`define REG_STATION_ADDR  4'h8
`define REG_STATION2      4'h9
`define REG_STATION3      4'hA
`define REG_DIAG_MASTER   4'hB
// Diagnostic master address before software fills it in
`define DIAG_MASTER_RESET 8'hFF
// Largest legal digit of an address switch
`define BCD_DIGIT_MAX     4'h9
// Diagnostic frame layout
`define FRAME_LEN         4'hD
`define FRAME_LAST        4'hC
`define DIAG_HEADER       8'h07
`define IDENT_CODE        16'h1234 // Arbitrary value, stands in for the real code
// Device diagnostic byte bit positions
`define DIAG_US_LOW       3
`define DIAG_OUT_OVL      5
`define DIAG_LOGIC_LOW    6
`define DIAG_US_OVL       7
// Interrupt status bit positions
`define IRQ_DIAG_CHANGE   0
`define IRQ_FRAME_DONE    1
// Station address range
`define STATION_MIN       7'h01
`define STATION_MAX       7'h63
`endif

/* File: src/diag_frame_sender.v */
`timescale 1ns/1ps
`include "fieldbus_io_consts.vh"

// Streams one diagnostic frame byte by byte on request
module diag_frame_sender (
  input wire clk,
  input wire resetn,
  input wire start,
  input wire [103:0] frame,
  output reg [7:0] byte_out,
  output reg byte_valid,
  output reg busy,
  output reg done
);
  reg [3:0] index_reg;

  // ==========================================
  // Sender: one telegram per start, never repeated
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      index_reg <= 4'h0;
      byte_out <= 8'h00;
      byte_valid <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      byte_valid <= 1'b0;
      if (!busy) begin
        if (start) begin
          busy <= 1'b1;
          index_reg <= 4'h0;
        end
      end else begin
        byte_out <= frame[index_reg*8 +: 8];
        byte_valid <= 1'b1;
        if (index_reg == `FRAME_LAST) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          index_reg <= index_reg + 4'h1;
        end
      end
    end
  end
endmodule

/* File: tb/fieldbus_io_checker.sv */
`timescale 1ns/1ps
`include "fieldbus_io_consts.vh"
// ====
// Port checks of the image block
module fieldbus_io_checker (
  input wire REF_CLK,
  input wire RESETN,
  input wire [3:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] RDATA,
  input wire [3:0] DIGITAL_OUTPUTS,
  input wire [3:0] OUTPUT_OVERLOAD,
  input wire SENSOR_SUPPLY_LOW,
  input wire [7:0] TELEGRAM_BYTE,
  input wire TELEGRAM_VALID
);
  reg [3:0] idx_reg;
  wire diag_rd = RD && ADDR == `REG_DIAG_STATUS;
  // Byte position inside the running telegram
  always @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN)
      idx_reg <= 4'h0;
    else if (TELEGRAM_VALID)
      idx_reg <= (idx_reg == 4'hC) ? 4'h0 : idx_reg + 4'h1;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  a_input_pad: assert property (RD && ADDR == `REG_INPUT_IMAGE |=> RDATA[7:4] == 4'h0)
    else $error("input pad set");
  // Three cycles covers any latency up to that, since writes are spaced
  a_output_drive: assert property (WR && ADDR == `REG_OUTPUT_IMAGE |->
    ##3 DIGITAL_OUTPUTS == $past(WDATA[3:0], 3)) else $error("outputs stale");
  a_diag_zero: assert property (diag_rd |=> RDATA[2:0] == 3'h0 && !RDATA[4])
    else $error("reserved diag set");
  a_sensor_low: assert property (diag_rd |=> RDATA[3] == $past(SENSOR_SUPPLY_LOW, 2))
    else $error("sensor low bit");
  a_out_ovl: assert property (diag_rd |=> RDATA[5] == |$past(OUTPUT_OVERLOAD, 2))
    else $error("overload bit");
  a_frame_header: assert property (TELEGRAM_VALID && idx_reg == 4'h6 |-> TELEGRAM_BYTE == `DIAG_HEADER)
    else $error("header byte");
  a_frame_zero: assert property (TELEGRAM_VALID && idx_reg > 4'h7 |-> TELEGRAM_BYTE[5:0] == 6'h00)
    else $error("reserved frame bits");
  a_frame_whole: assert property ($fell(TELEGRAM_VALID) |-> idx_reg == 4'h0)
    else $error("telegram cut short");
endmodule
bind fieldbus_io_image fieldbus_io_checker fieldbus_io_checker_i (.REF_CLK, .RESETN, .ADDR, .WDATA, .WR, .RD,
  .RDATA, .DIGITAL_OUTPUTS, .OUTPUT_OVERLOAD, .SENSOR_SUPPLY_LOW, .TELEGRAM_BYTE, .TELEGRAM_VALID);

/* File: tb/telegram_sink.sv */
`timescale 1ns/1ps
// ====
// Master end: counts bytes, keeps the last 13
module telegram_sink (
  input wire clk,
  input wire resetn,
  input wire [7:0] tbyte,
  input wire tvalid,
  output reg [7:0] nb,
  output reg [103:0] frame
);
  // Byte 0 comes first, so it ends on top
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nb <= 8'h00;
      frame <= 104'h0;
    end else if (tvalid) begin
      nb <= nb + 8'h01;
      frame <= {frame[95:0], tbyte};
    end
  end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`include "fieldbus_io_consts.vh"
module testbench;
  reg REF_CLK = 1'b0, RESETN = 1'b0, WR = 1'b0, RD = 1'b0;
  reg [3:0] ADDR = 4'h0, din = 4'h0, ovl = 4'h0, tens = 4'h4;
  reg [7:0] WDATA = 8'h00, want = 8'h00;
  reg [2:0] flg = 3'h0;
  wire [7:0] RDATA, tbyte, nb;
  wire [3:0] dout;
  wire tv, IRQ;
  wire [103:0] frame;
  wire [6:0] sta;
  wire stv;
  wire [15:0] idc = `IDENT_CODE;
  integer fails = 0, total_checks = 0, i;
  reg [26:0] rows [0:3];
  // ====
  // Clock, block and master end
  always #4 REF_CLK = ~REF_CLK;
  fieldbus_io_image fieldbus_io_image_i (.REF_CLK, .RESETN, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .DIGITAL_INPUTS(din), .DIGITAL_OUTPUTS(dout), .OUTPUT_OVERLOAD(ovl), .SENSOR_SUPPLY_LOW(flg[2]),
    .SENSOR_SUPPLY_OVERLOAD(flg[1]), .LOGIC_SUPPLY_LOW(flg[0]), .ADDRESS_TENS_SWITCH(tens),
    .ADDRESS_UNITS_SWITCH(4'h2), .STATION_ADDRESS(sta), .STATION_VALID(stv), .TELEGRAM_BYTE(tbyte),
    .TELEGRAM_VALID(tv), .IRQ);
  telegram_sink telegram_sink_i (.clk(REF_CLK), .resetn(RESETN), .tbyte, .tvalid(tv), .nb, .frame);
  // ====
  // Compare and bus tasks
  task chk(input string n, input [15:0] e, input [15:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("wrong value %0s expected %h seen %h", n, e, g);
      end
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task bus(input w, input [3:0] a, input [7:0] d);
    begin
      @(posedge REF_CLK);
      WR <= w;
      RD <= !w;
      ADDR <= a;
      WDATA <= d;
      @(posedge REF_CLK);
      WR <= 1'b0;
      RD <= 1'b0;
      #1 if (!w) chk("read data", {8'h00, d}, {8'h00, RDATA});
    end
  endtask
  // Bounded wait for the master to hold n bytes
  task wait_tg(input [7:0] n);
    integer k;
    begin
      for (k = 0; k < 60 && nb !== n; k = k + 1)
        @(posedge REF_CLK);
      if (nb !== n) begin
        chk("byte count", {8'h00, n}, {8'h00, nb});
        end_of_test;
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // ====
  // Rows: inputs, overloads, sensor low/ovl/logic low, output byte, diag byte
  initial begin
    rows[0] = {4'h1, 4'h0, 3'h4, 8'h5A, 8'h08};
    rows[1] = {4'h5, 4'h8, 3'h2, 8'hA5, 8'hA0};
    rows[2] = {4'hF, 4'h0, 3'h1, 8'hF0, 8'h40};
    rows[3] = {4'h8, 4'h6, 3'h7, 8'h3C, 8'hE8};
    repeat (6) @(posedge REF_CLK);
    RESETN <= 1'b1;
    @(posedge REF_CLK);
    tens <= 4'h9;
    bus(1'b1, `REG_IRQ_MASK, 8'h01);
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge REF_CLK);
      {din, ovl, flg} <= rows[i][26:16];
      bus(1'b1, `REG_OUTPUT_IMAGE, rows[i][15:8]);
      want = want + 8'h0D;
      wait_tg(want);
      bus(1'b0, `REG_INPUT_IMAGE, {4'h0, rows[i][26:23]});
      bus(1'b0, `REG_DIAG_STATUS, rows[i][7:0]);
      chk("outputs", {12'h000, rows[i][11:8]}, {12'h000, dout});
    end
    chk("frame", {`DIAG_HEADER, 8'hE8}, frame[55:40]);
    chk("ident", `IDENT_CODE, frame[71:56]);
    chk("irq", 16'h0001, {15'h0000, IRQ});
    bus(1'b1, `REG_IRQ_STATUS, 8'hFF);
    bus(1'b1, `REG_IRQ_MASK, 8'h00);
    chk("irq", 16'h0000, {15'h0000, IRQ});
    @(posedge REF_CLK);
    flg <= 3'h0;
    want = want + 8'h0D;
    wait_tg(want);
    repeat (3) @(posedge REF_CLK);
    bus(1'b0, `REG_IRQ_STATUS, 8'h03);
    chk("masked irq", 16'h0000, {15'h0000, IRQ});
    bus(1'b0, `REG_STATION_ADDR, 8'hAA);
    chk("station pins", 16'h00AA, {8'h00, stv, sta});
    bus(1'b0, 4'hF, 8'h00);
    bus(1'b1, `REG_FRAME_INDEX, 8'h04);
    bus(1'b0, `REG_FRAME_DATA, idc[15:8]);
    bus(1'b1, `REG_FRAME_INDEX, 8'h07);
    bus(1'b0, `REG_FRAME_DATA, 8'h20);
    bus(1'b0, `REG_DIAG_MASTER, `DIAG_MASTER_RESET);
    repeat (20) @(posedge REF_CLK);
    chk("bytes", {8'h00, want}, {8'h00, nb});
    // Mid-run reset clears the pins and takes the turned switches
    @(posedge REF_CLK);
    RESETN <= 1'b0;
    @(posedge REF_CLK);
    #1 chk("reset pins", 16'h0000, {11'h000, tv, dout});
    @(posedge REF_CLK);
    RESETN <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    #1 chk("station after reset", 16'h00DC, {8'h00, stv, sta});
    end_of_test;
  end
endmodule
